// [include/tf_decode_pkg.sv]
// Purpose: shared constants and types for the task file address decoder
// Assumes: host pins sampled on mclk; index comes from the option register
// Notes: offsets are the low four address bits of the task file
package tf_decode_pkg;

	// configuration index values
	localparam logic [1:0] IDX_MEM = 2'h0;
	localparam logic [1:0] IDX_CONTIG = 2'h1;
	localparam logic [1:0] IDX_PRI = 2'h2;
	localparam logic [1:0] IDX_SEC = 2'h3;

	// A9..A4 bases of the fixed I/O maps
	localparam logic [5:0] PRI_TASK = 6'h1f;
	localparam logic [5:0] PRI_ALT = 6'h3f;
	localparam logic [5:0] SEC_TASK = 6'h17;
	localparam logic [5:0] SEC_ALT = 6'h37;

	// task file offsets
	localparam logic [3:0] OFS_DATA = 4'h0;
	localparam logic [3:0] OFS_FAULT = 4'h1;
	localparam logic [3:0] OFS_TALLY = 4'h2;
	localparam logic [3:0] OFS_SECTOR = 4'h3;
	localparam logic [3:0] OFS_TRK_LO = 4'h4;
	localparam logic [3:0] OFS_TRK_HI = 4'h5;
	localparam logic [3:0] OFS_UNIT = 4'h6;
	localparam logic [3:0] OFS_STATE = 4'h7;
	localparam logic [3:0] OFS_EVEN = 4'h8;
	localparam logic [3:0] OFS_ODD = 4'h9;
	localparam logic [3:0] OFS_DUP_FAULT = 4'hd;
	localparam logic [3:0] OFS_SHADOW = 4'he;
	localparam logic [3:0] OFS_DRVADDR = 4'hf;
	// low offsets of the alternate pair in the fixed I/O maps
	localparam logic [3:0] OFS_IO_SHADOW = 4'h6;
	localparam logic [3:0] OFS_IO_DRVADDR = 4'h7;

	// read and write targets; shared offsets split by direction
	typedef enum logic [3:0] {
		SEL_NONE = 4'h0,
		SEL_DATA = 4'h1,
		SEL_FAULT = 4'h2,
		SEL_FEATURE = 4'h3,
		SEL_TALLY = 4'h4,
		SEL_SECTOR = 4'h5,
		SEL_TRK_LO = 4'h6,
		SEL_TRK_HI = 4'h7,
		SEL_UNIT = 4'h8,
		SEL_STATE = 4'h9,
		SEL_OPCODE = 4'ha,
		SEL_EVEN = 4'hb,
		SEL_ODD = 4'hc,
		SEL_SHADOW = 4'hd,
		SEL_CONTROL = 4'he,
		SEL_DRVADDR = 4'hf
	} tf_sel_t;

	typedef struct packed {
		logic [10:0] addr;
		logic reg_n;
		logic ce1_n;
		logic ce2_n;
		logic oe_n;
		logic we_n;
		logic iord_n;
		logic iowr_n;
		logic [15:0] data;
	} host_pins_t;

	typedef struct packed {
		tf_sel_t sel;
		logic byte_mode;
		logic [15:0] wdata;
	} tf_req_t;

	// attribute memory: tail of the tuple chain, even bytes only
	localparam logic [10:0] CIS_BASE = 11'h114;
	localparam logic [10:0] CIS_LAST = 11'h14a;
	localparam logic [10:0] CIS_NOLINK_ADDR = 11'h146;
	localparam logic [7:0] CIS_NO_LINK = 8'h14;
	localparam int CIS_LEN = 28;
	localparam logic [7:0] CIS_ROM [0:CIS_LEN-1] = '{
		8'h1b, 8'h0f, 8'hc3, 8'h41, 8'h99, 8'h01, 8'h55, 8'hea,
		8'h61, 8'h70, 8'h01, 8'h07, 8'h76, 8'h03, 8'h01, 8'hee,
		8'h20, 8'h1b, 8'h06, 8'h03, 8'h01, 8'h21, 8'hb5, 8'h1e,
		8'h4d, 8'h14, 8'h00, 8'hff
	};

	localparam logic [7:0] BYTE_ZERO = 8'h00;

endpackage

// [rtl/task_file_address_decoder.sv]
// Purpose: decode host pin cycles into task file selects and attribute reads
// Assumes: strobes and addresses are asynchronous to mclk and slow
// Notes: register contents live in the core; this block only steers
`timescale 1ns/1ps

module task_file_address_decoder (
	input wire logic mclk,
	input wire logic rstn,
	input wire logic [1:0] cfg_index,
	input wire logic [10:0] addr,
	input wire logic reg_n,
	input wire logic ce1_n,
	input wire logic ce2_n,
	input wire logic oe_n,
	input wire logic we_n,
	input wire logic iord_n,
	input wire logic iowr_n,
	input wire logic [15:0] d_in,
	output logic [15:0] d_out,
	output logic d_oe,
	input wire logic [15:0] tf_rdata,
	output tf_decode_pkg::tf_req_t req,
	output logic wr_pulse,
	output logic rd_active
);

	localparam int PW = $bits(tf_decode_pkg::host_pins_t);

	typedef enum logic [3:0] {
		ST_IDLE = 4'b0001,
		ST_READ = 4'b0010,
		ST_WRITE = 4'b0100,
		ST_HOLD = 4'b1000
	} cyc_state_t;

	// offset to target; direction splits the shared offsets
	function automatic tf_decode_pkg::tf_sel_t by_offset(
		input logic [3:0] o, input logic wr);
		tf_decode_pkg::tf_sel_t s;
		begin
			case (o)
				tf_decode_pkg::OFS_DATA: s = tf_decode_pkg::SEL_DATA;
				tf_decode_pkg::OFS_FAULT,
				tf_decode_pkg::OFS_DUP_FAULT: begin
					s = wr ? tf_decode_pkg::SEL_FEATURE
						: tf_decode_pkg::SEL_FAULT;
				end
				tf_decode_pkg::OFS_TALLY: s = tf_decode_pkg::SEL_TALLY;
				tf_decode_pkg::OFS_SECTOR: s = tf_decode_pkg::SEL_SECTOR;
				tf_decode_pkg::OFS_TRK_LO: s = tf_decode_pkg::SEL_TRK_LO;
				tf_decode_pkg::OFS_TRK_HI: s = tf_decode_pkg::SEL_TRK_HI;
				tf_decode_pkg::OFS_UNIT: s = tf_decode_pkg::SEL_UNIT;
				tf_decode_pkg::OFS_STATE: begin
					s = wr ? tf_decode_pkg::SEL_OPCODE
						: tf_decode_pkg::SEL_STATE;
				end
				tf_decode_pkg::OFS_EVEN: s = tf_decode_pkg::SEL_EVEN;
				tf_decode_pkg::OFS_ODD: s = tf_decode_pkg::SEL_ODD;
				tf_decode_pkg::OFS_SHADOW: begin
					s = wr ? tf_decode_pkg::SEL_CONTROL
						: tf_decode_pkg::SEL_SHADOW;
				end
				tf_decode_pkg::OFS_DRVADDR: begin
					// writes here are reserved and dropped
					s = wr ? tf_decode_pkg::SEL_NONE
						: tf_decode_pkg::SEL_DRVADDR;
				end
				default: s = tf_decode_pkg::SEL_NONE;
			endcase
			return s;
		end
	endfunction

	// fixed I/O maps: eight task registers or the alternate pair
	function automatic tf_decode_pkg::tf_sel_t fixed_map(
		input logic [10:0] a, input logic [5:0] task_base,
		input logic [5:0] alt_base, input logic wr);
		tf_decode_pkg::tf_sel_t s;
		begin
			s = tf_decode_pkg::SEL_NONE;
			if (a[9:4] == task_base && !a[3]) begin
				s = by_offset(a[3:0], wr);
			end else if (a[9:4] == alt_base &&
				(a[3:0] == tf_decode_pkg::OFS_IO_SHADOW ||
				a[3:0] == tf_decode_pkg::OFS_IO_DRVADDR)) begin
				s = by_offset({1'b1, a[2:0]}, wr);
			end
			return s;
		end
	endfunction

	function automatic tf_decode_pkg::tf_sel_t decode(input logic [1:0] idx,
		input logic attr_n, input logic [10:0] a, input logic io,
		input logic wr);
		tf_decode_pkg::tf_sel_t s;
		begin
			s = tf_decode_pkg::SEL_NONE;
			case (idx)
				tf_decode_pkg::IDX_MEM: begin
					if (!io && attr_n) begin
						if (a[10]) begin
							s = a[0] ? tf_decode_pkg::SEL_ODD
								: tf_decode_pkg::SEL_EVEN;
						end else begin
							s = by_offset(a[3:0], wr);
						end
					end
				end
				tf_decode_pkg::IDX_CONTIG: begin
					if (io && !attr_n) begin
						s = by_offset(a[3:0], wr);
					end
				end
				tf_decode_pkg::IDX_PRI: begin
					if (io && !attr_n) begin
						s = fixed_map(a, tf_decode_pkg::PRI_TASK,
							tf_decode_pkg::PRI_ALT, wr);
					end
				end
				tf_decode_pkg::IDX_SEC: begin
					if (io && !attr_n) begin
						s = fixed_map(a, tf_decode_pkg::SEC_TASK,
							tf_decode_pkg::SEC_ALT, wr);
					end
				end
				default: s = tf_decode_pkg::SEL_NONE;
			endcase
			return s;
		end
	endfunction

	// three-stage pin capture; a change counts when stages 2 and 3 agree
	tf_decode_pkg::host_pins_t raw;
	logic [PW-1:0] sync1;
	logic [PW-1:0] sync2;
	logic [PW-1:0] sync3;
	logic [PW-1:0] pin_q;
	tf_decode_pkg::host_pins_t pin;

	assign raw = '{addr: addr, reg_n: reg_n, ce1_n: ce1_n, ce2_n: ce2_n,
		oe_n: oe_n, we_n: we_n, iord_n: iord_n, iowr_n: iowr_n, data: d_in};
	assign pin = tf_decode_pkg::host_pins_t'(pin_q);

	genvar g;
	generate
		for (g = 0; g < PW; g++) begin : g_sync
			always_ff @(posedge mclk or negedge rstn) begin
				if (!rstn) begin
					sync1[g] <= 1'b1;
					sync2[g] <= 1'b1;
					sync3[g] <= 1'b1;
					pin_q[g] <= 1'b1;
				end else begin
					sync1[g] <= raw[g];
					sync2[g] <= sync1[g];
					sync3[g] <= sync2[g];
					if (sync2[g] == sync3[g]) begin
						pin_q[g] <= sync3[g];
					end
				end
			end
		end
	endgenerate

	// cycle classification
	wire card_sel = !pin.ce1_n || !pin.ce2_n;
	wire mem_rd = card_sel && !pin.oe_n;
	wire mem_wr = card_sel && !pin.we_n;
	wire io_rd = card_sel && !pin.iord_n;
	wire io_wr = card_sel && !pin.iowr_n;
	wire any_strobe = !pin.oe_n || !pin.we_n || !pin.iord_n || !pin.iowr_n;
	// byte cycle when only one enable is active
	wire byte_cyc = pin.ce1_n != pin.ce2_n;

	// a strobe of the wrong kind for the map decodes to nothing
	wire is_io = io_rd || io_wr;
	wire is_wr = mem_wr || io_wr;
	wire [10:0] cis_ofs = pin.addr - tf_decode_pkg::CIS_BASE;
	wire attr_hit = mem_rd && !pin.reg_n && !pin.addr[0] &&
		pin.addr >= tf_decode_pkg::CIS_BASE &&
		pin.addr <= tf_decode_pkg::CIS_LAST;
	wire [7:0] attr_byte = attr_hit ? tf_decode_pkg::CIS_ROM[cis_ofs[5:1]]
		: tf_decode_pkg::BYTE_ZERO;

	wire tf_decode_pkg::tf_sel_t hit_sel = decode(cfg_index, pin.reg_n,
		pin.addr, is_io, is_wr);
	cyc_state_t state;
	cyc_state_t next_state;
	wire go_rd = state == ST_IDLE && (mem_rd || io_rd) && !is_wr;
	wire go_wr = state == ST_IDLE && is_wr;
	wire rd_ok = hit_sel != tf_decode_pkg::SEL_NONE || attr_hit;
	wire wr_ok = hit_sel != tf_decode_pkg::SEL_NONE;

	always_comb begin
		next_state = state;
		case (state)
			ST_IDLE: begin
				if (go_wr) begin
					next_state = wr_ok ? ST_WRITE : ST_HOLD;
				end else if (go_rd) begin
					next_state = rd_ok ? ST_READ : ST_HOLD;
				end
			end
			ST_READ: next_state = any_strobe ? ST_READ : ST_IDLE;
			ST_WRITE: next_state = ST_HOLD;
			ST_HOLD: next_state = any_strobe ? ST_HOLD : ST_IDLE;
			default: next_state = ST_IDLE;
		endcase
	end

	logic attr_rd;
	logic [7:0] attr_q;

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			state <= ST_IDLE;
			req <= '0;
			attr_rd <= 1'b0;
			attr_q <= tf_decode_pkg::BYTE_ZERO;
		end else begin
			state <= next_state;
			if (go_wr || go_rd) begin
				req.sel <= hit_sel;
				req.byte_mode <= byte_cyc;
				req.wdata <= pin.data;
				attr_rd <= attr_hit;
				attr_q <= attr_byte;
			end
		end
	end

	// read data follows the core, or gives the attribute byte on attribute reads, while the strobe lasts
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			d_out <= '0;
			d_oe <= 1'b0;
		end else begin
			d_oe <= state == ST_READ && any_strobe;
			if (attr_rd) begin
				d_out <= {tf_decode_pkg::BYTE_ZERO, attr_q};
			end else if (req.byte_mode) begin
				d_out <= {tf_decode_pkg::BYTE_ZERO, tf_rdata[7:0]};
			end else begin
				d_out <= tf_rdata;
			end
		end
	end

	// handshakes are decoded straight from the state, and rd_active also from attr_rd
	assign wr_pulse = state == ST_WRITE;
	assign rd_active = state == ST_READ && !attr_rd;

	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!rstn);

	a_index_strobe_kind: assert property (
		go_wr && cfg_index == tf_decode_pkg::IDX_CONTIG && !io_wr
		|=> state == ST_HOLD && !wr_pulse)
		else $error("memory strobe accepted in an I/O map");

	a_mem_task_ofs: assert property (
		go_wr && cfg_index == tf_decode_pkg::IDX_MEM && mem_wr &&
		pin.reg_n && !pin.addr[10] &&
		pin.addr[3:0] == tf_decode_pkg::OFS_SECTOR
		|=> wr_pulse && req.sel == tf_decode_pkg::SEL_SECTOR)
		else $error("memory map offset 3 not decoded");

	a_mem_byte_pick: assert property (
		go_rd && cfg_index == tf_decode_pkg::IDX_MEM && pin.reg_n &&
		pin.addr[10]
		|=> req.sel == ($past(pin.addr[0]) ? tf_decode_pkg::SEL_ODD
			: tf_decode_pkg::SEL_EVEN))
		else $error("data byte choice wrong");

	a_mirror_fault: assert property (
		go_rd && cfg_index == tf_decode_pkg::IDX_CONTIG && io_rd &&
		!pin.reg_n && pin.addr[3:0] == tf_decode_pkg::OFS_DUP_FAULT
		|=> req.sel == tf_decode_pkg::SEL_FAULT ##1 d_oe)
		else $error("mirror fault offset not served");

	a_contig_opcode: assert property (
		go_wr && cfg_index == tf_decode_pkg::IDX_CONTIG && io_wr &&
		!pin.reg_n && pin.addr[3:0] == tf_decode_pkg::OFS_STATE
		|=> req.sel == tf_decode_pkg::SEL_OPCODE ##1 !wr_pulse)
		else $error("contiguous write to 7H not an opcode");

	a_primary_alt: assert property (
		go_rd && cfg_index == tf_decode_pkg::IDX_PRI && io_rd &&
		!pin.reg_n && pin.addr[9:4] == tf_decode_pkg::PRI_ALT &&
		pin.addr[3:0] == tf_decode_pkg::OFS_IO_SHADOW
		|=> req.sel == tf_decode_pkg::SEL_SHADOW && rd_active)
		else $error("primary alternate status missed");

	a_secondary_data: assert property (
		go_wr && cfg_index == tf_decode_pkg::IDX_SEC && io_wr &&
		!pin.reg_n && pin.addr[9:4] == tf_decode_pkg::SEC_TASK &&
		pin.addr[3:0] == tf_decode_pkg::OFS_DATA
		|=> wr_pulse && req.sel == tf_decode_pkg::SEL_DATA)
		else $error("secondary data write missed");

	a_drvaddr_write: assert property (
		go_wr && cfg_index == tf_decode_pkg::IDX_CONTIG && io_wr &&
		!pin.reg_n && pin.addr[3:0] == tf_decode_pkg::OFS_DRVADDR
		|=> !wr_pulse [*2])
		else $error("reserved write reached the core");

	a_chain_end: assert property (
		go_rd && mem_rd && !pin.reg_n &&
		pin.addr == tf_decode_pkg::CIS_NOLINK_ADDR
		|=> ##1 d_oe && d_out[7:0] == tf_decode_pkg::CIS_NO_LINK)
		else $error("no-link tuple not returned");

	a_word_data: assert property (
		state == ST_READ && !attr_rd && !req.byte_mode
		|=> d_out == $past(tf_rdata))
		else $error("word read data not forwarded");

	a_unmapped_quiet: assert property (
		go_rd && cfg_index == tf_decode_pkg::IDX_PRI && io_rd &&
		pin.addr[9:4] != tf_decode_pkg::PRI_TASK &&
		pin.addr[9:4] != tf_decode_pkg::PRI_ALT
		|=> state == ST_HOLD ##1 !d_oe)
		else $error("unmapped I/O read answered");

	c_mem_write: cover property (go_wr && mem_wr && wr_ok ##1 wr_pulse);
	c_io_read: cover property (go_rd && io_rd && rd_ok ##2 d_oe);
	c_attr_read: cover property (go_rd && attr_hit ##2 d_oe);
	c_unmapped: cover property (go_wr && !wr_ok ##1 state == ST_HOLD);

endmodule

// [tb/host_bus_model.sv]
// Purpose: host side of the card pin bus, one strobe cycle per call
// Assumes: pins driven by non-blocking assignment just after mclk rises
// Notes: released address and data lines show the inverse of last value
`timescale 1ns/1ps

module host_bus_model (
	input wire logic mclk,
	output tf_decode_pkg::host_pins_t pins,
	input wire logic d_oe,
	input wire logic [15:0] d_out
);
	initial pins = {11'h000, 7'h7f, 16'h0000};

	// addr held 4 edges before the strobe so the 4-edge filter settles
	task automatic access(input logic io, wr, rg, byt,
		input logic [10:0] a, input logic [15:0] wd, input int hold,
		output logic got, output logic [15:0] rd);
		got = 1'b0;
		rd = 16'h0000;
		@(posedge mclk);
		pins.addr <= a;
		pins.reg_n <= rg;
		pins.ce1_n <= 1'b0;
		pins.ce2_n <= byt;
		pins.data <= wr ? wd : ~pins.data;
		repeat (4) @(posedge mclk);
		pins.oe_n <= io | wr;
		pins.we_n <= io | ~wr;
		pins.iord_n <= ~io | wr;
		pins.iowr_n <= ~io | ~wr;
		repeat (hold) begin
			@(posedge mclk);
			if (d_oe === 1'b1) begin
				got = 1'b1;
				rd = d_out;
			end
		end
		pins.oe_n <= 1'b1;
		pins.we_n <= 1'b1;
		pins.iord_n <= 1'b1;
		pins.iowr_n <= 1'b1;
		repeat (4) @(posedge mclk);
		pins.ce1_n <= 1'b1;
		pins.ce2_n <= 1'b1;
		pins.addr <= ~a;
		pins.data <= ~pins.data;
		repeat (4) @(posedge mclk);
	endtask
endmodule

// [tb/tb_task_file_address_decoder.sv]
// Purpose: self-checking bench for the task file address decoder
// Assumes: core read data is a fixed pattern built from the select code
// Notes: target codes per offset are kept as nibble tables below
`timescale 1ns/1ps

`define CHK(act, exp) begin \
	comparisons++; \
	if ((act) !== (exp)) begin \
		miscompares++; \
		$display("ERROR t=%0t got %h exp %h", $time, (act), (exp)); \
	end \
end

module tb_task_file_address_decoder;
	// nibble n is the target code of offset n; 0 means no response
	localparam logic [63:0] RD_TAB = 64'hfd20_00cb_9876_5421;
	localparam logic [63:0] WR_TAB = 64'h0e30_00cb_a876_5431;
	logic mclk = 1'b0;
	logic rstn = 1'b0;
	logic [1:0] cfg_index = 2'h0;
	tf_decode_pkg::host_pins_t hp;
	tf_decode_pkg::tf_req_t req;
	tf_decode_pkg::tf_req_t last_req;
	logic [15:0] tf_rdata;
	logic [15:0] d_out;
	logic d_oe;
	logic wr_pulse;
	logic rd_active;
	logic rd_q = 1'b0;
	int npulse = 0;
	int nrd = 0;
	int miscompares = 0;
	int comparisons = 0;

	always #5 mclk = ~mclk;
	assign tf_rdata = {4'ha, req.sel, 4'h5, req.sel};

	always @(posedge mclk) begin
		rd_q <= rd_active;
		if (rd_active === 1'b1 && rd_q !== 1'b1) nrd <= nrd + 1;
		if (wr_pulse === 1'b1) begin
			npulse <= npulse + 1;
			last_req <= req;
		end
	end

	task_file_address_decoder dut_u (
		.mclk(mclk), .rstn(rstn), .cfg_index(cfg_index),
		.addr(hp.addr), .reg_n(hp.reg_n), .ce1_n(hp.ce1_n),
		.ce2_n(hp.ce2_n), .oe_n(hp.oe_n), .we_n(hp.we_n),
		.iord_n(hp.iord_n), .iowr_n(hp.iowr_n), .d_in(hp.data),
		.d_out(d_out), .d_oe(d_oe), .tf_rdata(tf_rdata), .req(req),
		.wr_pulse(wr_pulse), .rd_active(rd_active)
	);

	host_bus_model host_u (.mclk(mclk), .pins(hp), .d_oe(d_oe),
		.d_out(d_out));

	task automatic print_verdict();
		$display("comparisons %0d miscompares %0d", comparisons,
			miscompares);
		if (miscompares == 0 && comparisons > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	task automatic xfer(input logic io, wr, rg, byt, input logic [10:0] a,
		input logic [3:0] es, input int hold);
		logic got;
		logic [15:0] rd;
		logic [15:0] wd;
		logic [15:0] ex;
		int n0;
		int r0;
		wd = {5'h15, a};
		// byte cycles carry the low lane only, upper byte reads zero
		ex = byt ? {8'h00, 4'h5, es} : {4'ha, es, 4'h5, es};
		n0 = npulse;
		r0 = nrd;
		host_u.access(io, wr, rg, byt, a, wd, hold, got, rd);
		if (wr) begin
			`CHK(npulse - n0, (es == 4'h0) ? 0 : 1)
			if (es != 4'h0) begin
				`CHK(last_req.sel, es)
				`CHK(last_req.byte_mode, byt)
				`CHK(last_req.wdata, wd)
			end
		end else begin
			`CHK(got, es != 4'h0)
			if (es != 4'h0) `CHK(rd, ex)
			`CHK(nrd - r0, (es == 4'h0) ? 0 : 1)
		end
	endtask

	// write then a slower read at the same place
	task automatic pair(input logic io, rg, input logic [10:0] a,
		input int ti);
		xfer(io, 1'b1, rg, 1'b0, a, WR_TAB[ti*4 +: 4], 8);
		xfer(io, 1'b0, rg, 1'b0, a, RD_TAB[ti*4 +: 4], 12);
	endtask

	task automatic t_mem();
		cfg_index <= 2'h0;
		for (int o = 0; o < 16; o++) begin
			pair(0, 1, {7'h35, o[3:0]}, o);
		end
		xfer(0, 1, 1, 0, 11'h7fe, 4'hb, 8);
		xfer(0, 0, 1, 0, 11'h401, 4'hc, 12);
		xfer(0, 1, 1, 1, 11'h008, 4'hb, 8);
		xfer(0, 0, 1, 1, 11'h009, 4'hc, 12);
		$display("test mem_map done");
	endtask

	task automatic t_contig();
		cfg_index <= 2'h1;
		for (int o = 0; o < 16; o++) begin
			pair(1, 0, {7'h6a, o[3:0]}, o);
		end
		$display("test contig_io done");
	endtask

	task automatic t_fixed();
		logic [5:0] tb_b;
		logic [5:0] al_b;
		logic [5:0] ot_b;
		for (int i = 2; i < 4; i++) begin
			cfg_index <= i[1:0];
			tb_b = (i == 2) ? 6'h1f : 6'h17;
			al_b = (i == 2) ? 6'h3f : 6'h37;
			ot_b = (i == 2) ? 6'h17 : 6'h1f;
			for (int o = 0; o < 8; o++) begin
				pair(1, 0, {1'b1, tb_b, 1'b0, o[2:0]}, o);
			end
			pair(1, 0, {1'b0, al_b, 4'h6}, 14);
			pair(1, 0, {1'b1, al_b, 4'h7}, 15);
			pair(1, 0, {1'b0, tb_b, 4'h8}, 10);
			pair(1, 0, {1'b0, al_b, 4'h0}, 10);
			pair(1, 0, {1'b0, ot_b, 4'h1}, 10);
		end
		$display("test fixed_io done");
	endtask

	// wrong strobe kind or wrong space level gets no answer
	task automatic t_refuse();
		cfg_index <= 2'h0;
		xfer(1, 1, 0, 0, 11'h001, 4'h0, 8);
		xfer(0, 1, 0, 0, 11'h007, 4'h0, 8);
		cfg_index <= 2'h1;
		xfer(0, 1, 1, 0, 11'h002, 4'h0, 8);
		cfg_index <= 2'h2;
		xfer(0, 1, 1, 0, 11'h1f7, 4'h0, 8);
		xfer(1, 0, 1, 0, 11'h1f7, 4'h0, 8);
		$display("test refuse done");
	endtask

	task automatic t_attr();
		logic [18:0] tab [5] = '{{11'h146, 8'h14}, {11'h14a, 8'hff},
			{11'h126, 8'h70}, {11'h12c, 8'h76}, {11'h13a, 8'h03}};
		logic got;
		logic [15:0] rd;
		int r0;
		cfg_index <= 2'h0;
		foreach (tab[k]) begin
			r0 = nrd;
			host_u.access(0, 0, 0, 0, tab[k][18:8], 16'h0000, 14, got, rd);
			`CHK(got, 1'b1)
			`CHK(rd[7:0], tab[k][7:0])
			`CHK(rd[15:8], 8'h00)
			`CHK(nrd - r0, 0)
		end
		$display("test attr_table done");
	endtask

	initial begin
		repeat (20) @(posedge mclk);
		rstn <= 1'b1;
		t_mem();
		t_contig();
		t_fixed();
		t_refuse();
		t_attr();
		print_verdict();
	end

	// the run needs about 3000 cycles; over six times that means a hang
	initial begin
		repeat (20000) @(posedge mclk);
		miscompares++;
		$display("watchdog expired");
		print_verdict();
	end
endmodule
